// ==== design/pwmcs_pkg.sv ====
/*
 * constants for the pwm control slice: register offsets, field layouts,
 * mode and function codes.
 * assumes a byte-addressed register port whose offsets are byte indices.
 */
package pwmcs_pkg;
    // ------------------------------------------------------------
    // register byte addresses, decoded in full
    // ------------------------------------------------------------
    localparam logic [31:0] OFS_PORT_DIRECTION_LOW = 32'hfffe3a06;
    localparam logic [31:0] OFS_PORT_FUNC_UPPER = 32'hfffe3a10;
    localparam logic [31:0] OFS_PORT_FUNC_LOWER = 32'hfffe3a12;
    localparam logic [31:0] OFS_CHANNEL3_MODE = 32'hfffe4202;
    localparam logic [31:0] OFS_CHANNEL4_MODE = 32'hfffe4203;
    localparam logic [31:0] OFS_CH3_IRQ_ENABLE = 32'hfffe4208;
    localparam logic [31:0] OFS_OUTPUT_MASTER_EN = 32'hfffe420a;
    localparam logic [31:0] OFS_COUNTER_START = 32'hffff4280;
    localparam logic [31:0] OFS_IRQ_PRIORITY = 32'hfffe0f00;
    localparam logic [31:0] OFS_STATUS = 32'hfffe0f04;
    // ------------------------------------------------------------
    // field layouts and codes
    // ------------------------------------------------------------
    localparam logic [3:0] MODE_COMPLEMENTARY_3 = 4'hf;
    localparam logic [3:0] MODE_COMPLEMENTARY_2 = 4'he;
    localparam logic [3:0] MODE_COMPLEMENTARY_1 = 4'hd;
    localparam int MODE_MSB = 3;
    localparam int IRQ_EN_A_BIT = 0;
    localparam int PRIO_CH3_LSB = 4;
    localparam int PRIO_W = 4;
    localparam int FSEL_W = 3;
    localparam logic [2:0] FSEL_TIMER = 3'h6;
    localparam logic [2:0] FSEL_PORT = 3'h0;
    localparam int NUM_TPINS = 6;
    localparam int NUM_CHANNELS = 5;
    localparam int NUM_PORT_PINS = 16;
    localparam int NUM_UPPER_PINS = 8;
    localparam int MAX_PRIO = 15;
    // output enable bit order: 4d 4c 3d 4b 4a 3b, msb first
    localparam int OE_3B = 0;
    localparam int OE_4A = 1;
    localparam int OE_4B = 2;
    localparam int OE_3D = 3;
    localparam int OE_4C = 4;
    localparam int OE_4D = 5;
    localparam int CH3 = 3;
    localparam int CH4 = 4;
    // start bits of the complementary pair sit in the top two bits
    localparam int CST_CH3_BIT = 6;
    localparam int CST_CH4_BIT = 7;
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [15:0] RST_HALF = 16'h0000;
endpackage

// ==== design/pwmcs_route_if.sv ====
/*
 * interface carrying pin routing settings and timer waveforms
 * between the control slice and its pin mux.
 * assumes one clock domain; no clocking block.
 */
`timescale 1ns/1ps
interface pwmcs_route_if;
    import pwmcs_pkg::*;
    logic [NUM_PORT_PINS*FSEL_W-1:0] funcSel;
    logic [NUM_PORT_PINS-1:0] portDir;
    logic [NUM_PORT_PINS-1:0] portOut;
    logic [NUM_PORT_PINS-1:0] timerOut;
    logic [NUM_PORT_PINS-1:0] timerOutEn;
    logic [NUM_PORT_PINS-1:0] padOut;
    logic [NUM_PORT_PINS-1:0] padOe;
    modport ctrl (output funcSel, portDir, portOut, timerOut, timerOutEn,
        input padOut, padOe);
    modport mux (input funcSel, portDir, portOut, timerOut, timerOutEn,
        output padOut, padOe);
endinterface

// ==== design/pwmcs_pin_mux.sv ====
/*
 * port pin mux: picks per pin the timer or the general port function
 * and applies the direction bit; registered so pads see flop outputs.
 * assumes the control slice feeds it through pwmcs_route_if.
 */
`timescale 1ns/1ps
module pwmcs_pin_mux
    import pwmcs_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    pwmcs_route_if.mux rt
);
    logic [NUM_PORT_PINS-1:0] out_r;
    logic [NUM_PORT_PINS-1:0] oe_r;

    assign rt.padOut = out_r;
    assign rt.padOe = oe_r;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= RST_HALF;
            oe_r <= RST_HALF;
        end else if (clkEn) begin
            for (int i = 0; i < NUM_PORT_PINS; i++) begin
                // other function codes leave the pin an undriven input
                if (rt.funcSel[i*FSEL_W +: FSEL_W] == FSEL_TIMER) begin
                    out_r[i] <= rt.timerOut[i];
                    oe_r[i] <= rt.portDir[i] & rt.timerOutEn[i];
                end else if (rt.funcSel[i*FSEL_W +: FSEL_W] == FSEL_PORT) begin
                    out_r[i] <= rt.portOut[i];
                    oe_r[i] <= rt.portDir[i];
                end else begin
                    out_r[i] <= 1'b0;
                    oe_r[i] <= 1'b0;
                end
            end
        end
    end

    AST_TIMER_OE_GATED: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && rt.funcSel[(NUM_PORT_PINS-1)*FSEL_W +: FSEL_W] == FSEL_TIMER
            && !rt.timerOutEn[NUM_PORT_PINS-1])
        |=> !oe_r[NUM_PORT_PINS-1])
        else $error("timer drove a pin whose output enable is clear");
    AST_PORT_DIR_INPUT: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && !rt.portDir[NUM_PORT_PINS-1]) |=> !oe_r[NUM_PORT_PINS-1])
        else $error("pin configured as input is driven");
endmodule

// ==== design/pwmcs_top.sv ====
/*
 * control slice of a paired-channel complementary pwm timer: mode
 * slaving of channel 4, per-pin output enables, compare-a interrupt,
 * counter start bits, interrupt priority and port pin routing.
 * assumes a simple strobe register port and an external counter/compare
 * core that supplies the compare-a flag and pwm waveforms.
 */
`timescale 1ns/1ps

// Overview of operation
// - complementary mode on channel 3 overrides channel 4 mode register
// - six output enable bits; 1 lets the timer drive its pin
// - compare-a irq raised when flag sets while irq enable is 1
// - one start bit per channel 0..4; 1 counts, 0 stops
// - 4-bit priority, levels 0..15; bits 7:4 hold channel-3 compare level
// - function select 110 routes port pin to timer function
// - function select 000 routes port pin to general port
// - direction bit 1 makes pin output, 0 input, timer pins too
module pwmcs_top
    import pwmcs_pkg::*;
#(
    parameter int ADDR_W = 32
)
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    input wire logic [ADDR_W-1:0] regAddr,
    input wire logic [15:0] regWdata,
    input wire logic regWr,
    input wire logic regRd,
    output logic [15:0] regRdata,
    input wire logic compareAFlag,
    input wire logic [NUM_TPINS-1:0] pwmWave,
    input wire logic [NUM_PORT_PINS-1:0] portOutData,
    input wire logic [NUM_PORT_PINS-1:0] padIn,
    output logic [NUM_PORT_PINS-1:0] padOut,
    output logic [NUM_PORT_PINS-1:0] padOe,
    output logic [NUM_PORT_PINS-1:0] portInData,
    output logic [NUM_CHANNELS-1:0] countRun,
    output logic [MODE_MSB:0] ch4ModeEff,
    output logic ch3CompareAIrq,
    output logic [PRIO_W-1:0] ch3IrqLevel
);
    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [15:0] portDirectionLow_r;
    logic [15:0] portFunctionUpper_r;
    logic [15:0] portFunctionLower_r;
    logic [7:0] channel3Mode_r;
    logic [7:0] channel4Mode_r;
    logic [7:0] channel3InterruptEnable_r;
    logic [7:0] outputMasterEnable_r;
    logic [7:0] counterStart_r;
    logic [15:0] irqPriority_r;
    logic [15:0] regRdata_r;
    logic [15:0] regRdata_nxt;
    logic compareAFlagDly_r;
    logic compareAIrqPend_r;
    logic [NUM_CHANNELS-1:0] countRun_r;
    logic [MODE_MSB:0] ch4ModeEff_r;
    logic [MODE_MSB:0] ch4ModeEff_nxt;
    logic [PRIO_W-1:0] ch3IrqLevel_r;
    logic [NUM_PORT_PINS-1:0] portIn_r;
    logic [NUM_PORT_PINS-1:0] timerPinOut;
    logic [NUM_PORT_PINS-1:0] timerPinEn;

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [31:0] ofs);
        hit = (a == ofs[ADDR_W-1:0]);
    endfunction

    function automatic logic [NUM_CHANNELS-1:0] runBits(input logic [7:0] st);
        runBits = {st[CST_CH4_BIT], st[CST_CH3_BIT], st[CH3-1:0]};
    endfunction

    function automatic logic isComplementary(input logic [7:0] md);
        isComplementary = (md[MODE_MSB:0] == MODE_COMPLEMENTARY_1)
            || (md[MODE_MSB:0] == MODE_COMPLEMENTARY_2)
            || (md[MODE_MSB:0] == MODE_COMPLEMENTARY_3);
    endfunction

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            portDirectionLow_r <= RST_HALF;
            portFunctionUpper_r <= RST_HALF;
            portFunctionLower_r <= RST_HALF;
        end else if (clkEn && regWr) begin
            if (hit(regAddr, OFS_PORT_DIRECTION_LOW)) begin
                portDirectionLow_r <= regWdata;
            end
            if (hit(regAddr, OFS_PORT_FUNC_UPPER)) begin
                portFunctionUpper_r <= regWdata;
            end
            if (hit(regAddr, OFS_PORT_FUNC_LOWER)) begin
                portFunctionLower_r <= regWdata;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            channel3Mode_r <= RST_BYTE;
            channel4Mode_r <= RST_BYTE;
            channel3InterruptEnable_r <= RST_BYTE;
            outputMasterEnable_r <= RST_BYTE;
            irqPriority_r <= RST_HALF;
        end else if (clkEn && regWr) begin
            if (hit(regAddr, OFS_CHANNEL3_MODE)) begin
                channel3Mode_r <= regWdata[7:0];
            end
            if (hit(regAddr, OFS_CHANNEL4_MODE)) begin
                channel4Mode_r <= regWdata[7:0];
            end
            if (hit(regAddr, OFS_CH3_IRQ_ENABLE)) begin
                channel3InterruptEnable_r <= regWdata[7:0];
            end
            if (hit(regAddr, OFS_OUTPUT_MASTER_EN)) begin
                outputMasterEnable_r <= regWdata[7:0];
            end
            if (hit(regAddr, OFS_IRQ_PRIORITY)) begin
                irqPriority_r <= regWdata;
            end
        end
    end

    // one write carries all start bits, so channels 3 and 4 start on the
    // same edge; separate writes would skew the complementary pair
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            counterStart_r <= RST_BYTE;
        end else if (clkEn && regWr && hit(regAddr, OFS_COUNTER_START)) begin
            counterStart_r <= regWdata[7:0];
        end
    end

    // ------------------------------------------------------------
    // counter run outputs and channel 4 mode slaving
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            countRun_r <= '0;
        end else if (clkEn) begin
            // channels 0..2 take the low bits, the pair takes the top two
            countRun_r <= runBits(counterStart_r);
        end
    end

    always_comb begin
        if (isComplementary(channel3Mode_r)) begin
            ch4ModeEff_nxt = channel3Mode_r[MODE_MSB:0];
        end else begin
            ch4ModeEff_nxt = channel4Mode_r[MODE_MSB:0];
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ch4ModeEff_r <= '0;
            ch3IrqLevel_r <= '0;
        end else if (clkEn) begin
            ch4ModeEff_r <= ch4ModeEff_nxt;
            ch3IrqLevel_r <= irqPriority_r[PRIO_CH3_LSB +: PRIO_W];
        end
    end

    // ------------------------------------------------------------
    // compare-a interrupt: rising flag while enabled raises request;
    // request follows the flag so software clears it at the core
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            compareAFlagDly_r <= 1'b0;
            compareAIrqPend_r <= 1'b0;
        end else if (clkEn) begin
            compareAFlagDly_r <= compareAFlag;
            if (!compareAFlag || !channel3InterruptEnable_r[IRQ_EN_A_BIT]) begin
                compareAIrqPend_r <= 1'b0;
            end else if (!compareAFlagDly_r) begin
                compareAIrqPend_r <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // timer waveform to port pin positions
    // ------------------------------------------------------------
    always_comb begin
        timerPinOut = '0;
        timerPinEn = '0;
        // pins 9 11 12 13 14 15 carry 3b 3d 4a 4b 4c 4d; pin 8 (3a) is tied low with no enable
        timerPinOut[8] = 1'b0;
        timerPinEn[8] = 1'b0;
        timerPinOut[9] = pwmWave[OE_3B];
        timerPinEn[9] = outputMasterEnable_r[OE_3B];
        timerPinOut[11] = pwmWave[OE_3D];
        timerPinEn[11] = outputMasterEnable_r[OE_3D];
        timerPinOut[12] = pwmWave[OE_4A];
        timerPinEn[12] = outputMasterEnable_r[OE_4A];
        timerPinOut[13] = pwmWave[OE_4B];
        timerPinEn[13] = outputMasterEnable_r[OE_4B];
        timerPinOut[14] = pwmWave[OE_4C];
        timerPinEn[14] = outputMasterEnable_r[OE_4C];
        timerPinOut[15] = pwmWave[OE_4D];
        timerPinEn[15] = outputMasterEnable_r[OE_4D];
    end

    pwmcs_route_if rt ();

    assign rt.funcSel = {portFunctionUpper_r[14:12], portFunctionUpper_r[10:8],
        portFunctionUpper_r[6:4], portFunctionUpper_r[2:0],
        portFunctionLower_r[14:12], portFunctionLower_r[10:8],
        portFunctionLower_r[6:4], portFunctionLower_r[2:0],
        {NUM_UPPER_PINS*FSEL_W{1'b0}}};
    assign rt.portDir = portDirectionLow_r;
    assign rt.portOut = portOutData;
    assign rt.timerOut = timerPinOut;
    assign rt.timerOutEn = timerPinEn;

    pwmcs_pin_mux u_mux (
        .clk(clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .rt(rt)
    );

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            portIn_r <= RST_HALF;
        end else if (clkEn) begin
            portIn_r <= padIn & ~portDirectionLow_r;
        end
    end

    // ------------------------------------------------------------
    // register reads, one cycle later; unmapped reads return zero
    // ------------------------------------------------------------
    always_comb begin
        regRdata_nxt = RST_HALF;
        if (hit(regAddr, OFS_PORT_DIRECTION_LOW)) begin
            regRdata_nxt = portDirectionLow_r;
        end else if (hit(regAddr, OFS_PORT_FUNC_UPPER)) begin
            regRdata_nxt = portFunctionUpper_r;
        end else if (hit(regAddr, OFS_PORT_FUNC_LOWER)) begin
            regRdata_nxt = portFunctionLower_r;
        end else if (hit(regAddr, OFS_CHANNEL3_MODE)) begin
            regRdata_nxt = {8'h00, channel3Mode_r};
        end else if (hit(regAddr, OFS_CHANNEL4_MODE)) begin
            regRdata_nxt = {8'h00, channel4Mode_r};
        end else if (hit(regAddr, OFS_CH3_IRQ_ENABLE)) begin
            regRdata_nxt = {8'h00, channel3InterruptEnable_r};
        end else if (hit(regAddr, OFS_OUTPUT_MASTER_EN)) begin
            regRdata_nxt = {8'h00, outputMasterEnable_r};
        end else if (hit(regAddr, OFS_COUNTER_START)) begin
            regRdata_nxt = {8'h00, counterStart_r};
        end else if (hit(regAddr, OFS_IRQ_PRIORITY)) begin
            regRdata_nxt = irqPriority_r;
        end else if (hit(regAddr, OFS_STATUS)) begin
            regRdata_nxt = {11'h000, compareAIrqPend_r, ch4ModeEff_r};
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            regRdata_r <= RST_HALF;
        end else if (clkEn) begin
            regRdata_r <= regRd ? regRdata_nxt : RST_HALF;
        end
    end

    assign regRdata = regRdata_r;
    assign padOut = rt.padOut;
    assign padOe = rt.padOe;
    assign portInData = portIn_r;
    assign countRun = countRun_r;
    assign ch4ModeEff = ch4ModeEff_r;
    assign ch3CompareAIrq = compareAIrqPend_r;
    assign ch3IrqLevel = ch3IrqLevel_r;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // the top pin is watched: it carries a timer waveform with its own enable,
    // and a port-function pin may be driven whatever the enable says
    logic topPinTimer;
    assign topPinTimer = rt.funcSel[(NUM_PORT_PINS-1)*FSEL_W +: FSEL_W] == FSEL_TIMER;

    sequence flagRiseEnabled;
        clkEn && compareAFlag && !compareAFlagDly_r
            && channel3InterruptEnable_r[IRQ_EN_A_BIT];
    endsequence

    AST_CH4_SLAVED: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && isComplementary(channel3Mode_r))
        |=> (ch4ModeEff_r == $past(channel3Mode_r[MODE_MSB:0])))
        else $error("channel 4 mode not slaved to channel 3");

    AST_CH4_OWN: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && !isComplementary(channel3Mode_r))
        |=> (ch4ModeEff_r == $past(channel4Mode_r[MODE_MSB:0])))
        else $error("channel 4 mode not its own");

    AST_IRQ_ON_RISE: assert property (@(posedge clk) disable iff (!rst_n)
        flagRiseEnabled |=> ch3CompareAIrq)
        else $error("compare-a request missing");

    AST_IRQ_NO_LATE: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && compareAFlagDly_r && !ch3CompareAIrq) |=> !ch3CompareAIrq)
        else $error("compare-a request without a fresh flag");

    AST_IRQ_NEEDS_EN: assert property (@(posedge clk) disable iff (!rst_n)
        ch3CompareAIrq |-> channel3InterruptEnable_r[IRQ_EN_A_BIT] || $past(clkEn) == 1'b0
            || $past(channel3InterruptEnable_r[IRQ_EN_A_BIT]))
        else $error("compare-a request without enable");

    AST_START_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && regWr && hit(regAddr, OFS_COUNTER_START))
        ##1 clkEn |=> (countRun == runBits($past(regWdata[7:0], 2))))
        else $error("counter run does not follow start write");

    AST_PAIR_TOGETHER: assert property (@(posedge clk) disable iff (!rst_n)
        $rose(countRun[CH3]) |-> countRun[CH4] || !counterStart_r[CST_CH4_BIT]
            || $past(countRun[CH4]))
        else $error("complementary pair started apart");

    AST_PRIO_LEVEL: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn |=> (ch3IrqLevel <= PRIO_W'(MAX_PRIO))
            && ch3IrqLevel == $past(irqPriority_r[PRIO_CH3_LSB +: PRIO_W]))
        else $error("priority level wrong");

    AST_OE_WRITE: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && regWr && hit(regAddr, OFS_OUTPUT_MASTER_EN))
        |=> outputMasterEnable_r == $past(regWdata[7:0]))
        else $error("output enable write lost");

    AST_OE_BLOCKS: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && topPinTimer && !outputMasterEnable_r[OE_4D]) |=> !padOe[NUM_PORT_PINS-1])
        else $error("disabled timer pin is driven");

    AST_PIN_TIMER_FOLLOWS: assert property (@(posedge clk) disable iff (!rst_n)
        (clkEn && topPinTimer)
        |=> padOut[NUM_PORT_PINS-1] == $past(pwmWave[OE_4D]))
        else $error("timer waveform not routed to its pin");
endmodule

// ==== sim/pwmcs_gate_drv.sv ====
/*
 * pin-side model: the gate drivers and board wiring on the port pins.
 * assumes the slice drives padOut/padOe and reads back padIn; the bench
 * drives extLevel in place of whatever sources the undriven lines.
 */
`timescale 1ns/1ps
module pwmcs_gate_drv
    import pwmcs_pkg::*;
(
    input wire logic [NUM_PORT_PINS-1:0] padOut,
    input wire logic [NUM_PORT_PINS-1:0] padOe,
    input wire logic [NUM_PORT_PINS-1:0] extLevel,
    output logic [NUM_PORT_PINS-1:0] padIn
);
    // gate driver inputs never drive back; a released pin shows the board level,
    // not the last driven value, so stale data cannot pass for a good read
    assign padIn = (padOe & padOut) | (~padOe & extLevel);
endmodule

// ==== sim/pwm_channel_start_output_routing_tb.sv ====
/*
 * self-checking bench for the pwm control slice: registers, mode slaving,
 * counter start, compare-a interrupt, priority and pin routing.
 * assumes pwmcs_top and the pin-side model pwmcs_gate_drv.
 */
`timescale 1ns/1ps
module pwm_channel_start_output_routing_tb
    import pwmcs_pkg::*;
();
    logic clk, rst_n, clkEn, regWr, regRd, compareAFlag, ch3CompareAIrq;
    logic [31:0] regAddr;
    logic [15:0] regWdata, regRdata, portOutData, padIn, padOut, padOe, portInData, extLevel;
    logic [15:0] sFu, sFl, sDir;
    logic [7:0] sOe;
    logic [5:0] pwmWave;
    logic [4:0] countRun;
    logic [3:0] ch4ModeEff, ch3IrqLevel;
    int n_fail, tests_run;

    initial clk = 1'b0;
    always #20 clk = ~clk;

    pwmcs_top #(.ADDR_W(32)) DUT (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .regAddr(regAddr),
        .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
        .compareAFlag(compareAFlag), .pwmWave(pwmWave), .portOutData(portOutData),
        .padIn(padIn), .padOut(padOut), .padOe(padOe), .portInData(portInData),
        .countRun(countRun), .ch4ModeEff(ch4ModeEff), .ch3CompareAIrq(ch3CompareAIrq),
        .ch3IrqLevel(ch3IrqLevel));
    pwmcs_gate_drv gates (.padOut(padOut), .padOe(padOe), .extLevel(extLevel), .padIn(padIn));

    // ------------------------------------------------------------
    // bus and compare helpers
    // ------------------------------------------------------------
    task automatic chkv(input logic [15:0] got, input logic [15:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // one idle edge after each strobe keeps a driver from assigning twice per step
    task automatic wr(input logic [31:0] a, input logic [15:0] d);
        @(posedge clk);
        regAddr <= a; regWdata <= d; regWr <= 1'b1;
        @(posedge clk);
        regWr <= 1'b0;
    endtask
    task automatic rd(input logic [31:0] a, output logic [15:0] d);
        @(posedge clk);
        regAddr <= a; regRd <= 1'b1;
        @(posedge clk);
        regRd <= 1'b0;
        #1 d = regRdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic conclude();
        $display("tests_run=%0d n_fail=%0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] adr[10] = '{OFS_PORT_DIRECTION_LOW, OFS_PORT_FUNC_UPPER, OFS_PORT_FUNC_LOWER,
            OFS_CHANNEL3_MODE, OFS_CHANNEL4_MODE, OFS_CH3_IRQ_ENABLE, OFS_OUTPUT_MASTER_EN,
            OFS_COUNTER_START, OFS_IRQ_PRIORITY, OFS_STATUS};
        logic [15:0] d;
        foreach (adr[i]) begin
            rd(adr[i], d);
            chkv(d, 16'h0000, "reset value");
        end
        chkv(padOe, 16'h0000, "reset pads");
        wr(OFS_OUTPUT_MASTER_EN, 16'hffff);
        rd(OFS_OUTPUT_MASTER_EN, d);
        chkv(d, 16'h00ff, "enable byte");
        wr(32'hfffe4300, 16'h1234);
        rd(32'hfffe4300, d);
        chkv(d, 16'h0000, "unmapped");
        @(posedge clk);
        clkEn <= 1'b0;
        wr(OFS_COUNTER_START, 16'h00c0);
        @(posedge clk);
        clkEn <= 1'b1;
        rd(OFS_COUNTER_START, d);
        chkv(d, 16'h0000, "frozen write");
        wr(OFS_OUTPUT_MASTER_EN, 16'h0000);
        $display("test regs done");
    endtask

    task automatic t_mode();
        logic [3:0] codes[3] = '{MODE_COMPLEMENTARY_1, MODE_COMPLEMENTARY_2, MODE_COMPLEMENTARY_3};
        logic [15:0] d;
        wr(OFS_CHANNEL4_MODE, 16'h0002);
        settle(2);
        chkv(16'(ch4ModeEff), 16'h0002, "own mode");
        foreach (codes[i]) begin
            wr(OFS_CHANNEL3_MODE, {12'h003, codes[i]});
            settle(2);
            chkv(16'(ch4ModeEff), 16'(codes[i]), "slaved mode");
        end
        rd(OFS_CHANNEL4_MODE, d);
        chkv(d, 16'h0002, "mode kept");
        wr(OFS_CHANNEL3_MODE, 16'h0000);
        $display("test mode done");
    endtask

    task automatic t_start();
        logic [7:0] v[4] = '{8'hc0, 8'h07, 8'hc5, 8'h00};
        logic [15:0] d;
        foreach (v[i]) begin
            wr(OFS_COUNTER_START, {8'h00, v[i]});
            settle(1);
            chkv(16'(countRun), {11'h000, v[i][7:6], v[i][2:0]}, "run bits");
            rd(OFS_COUNTER_START, d);
            chkv(d, {8'h00, v[i]}, "start readback");
        end
        $display("test start done");
    endtask

    task automatic t_irq();
        wr(OFS_CH3_IRQ_ENABLE, 16'h0000);
        @(posedge clk);
        compareAFlag <= 1'b1;
        settle(3);
        chkv(16'(ch3CompareAIrq), 16'h0000, "masked irq");
        @(posedge clk);
        compareAFlag <= 1'b0;
        wr(OFS_CH3_IRQ_ENABLE, 16'h0001);
        @(posedge clk);
        compareAFlag <= 1'b1;
        settle(2);
        chkv(16'(ch3CompareAIrq), 16'h0001, "raised irq");
        wr(OFS_CH3_IRQ_ENABLE, 16'h0000);
        settle(2);
        chkv(16'(ch3CompareAIrq), 16'h0000, "disabled irq");
        wr(OFS_CH3_IRQ_ENABLE, 16'h0001);
        settle(2);
        chkv(16'(ch3CompareAIrq), 16'h0000, "late enable");
        @(posedge clk);
        compareAFlag <= 1'b0;
        $display("test irq done");
    endtask

    task automatic t_prio();
        logic [15:0] v[3] = '{16'h00f0, 16'h0050, 16'h0000};
        foreach (v[i]) begin
            wr(OFS_IRQ_PRIORITY, v[i]);
            settle(2);
            chkv(16'(ch3IrqLevel), 16'(v[i][7:4]), "priority");
        end
        $display("test prio done");
    endtask

    // expected pad state from the shadows: pin -> waveform/enable bit, -1 none
    task automatic chkpins(input string what);
        int tmap[16] = '{-1, -1, -1, -1, -1, -1, -1, -1, -1, 0, -1, 3, 1, 2, 4, 5};
        logic [15:0] eOe, eOut;
        logic [2:0] f;
        eOe = '0;
        eOut = '0;
        for (int p = 0; p < 16; p++) begin
            f = p >= 12 ? sFu[4*(p-12)+:3] : (p >= 8 ? sFl[4*(p-8)+:3] : FSEL_PORT);
            if (f == FSEL_PORT) begin
                eOe[p] = sDir[p];
                eOut[p] = portOutData[p];
            end else if (f == FSEL_TIMER && tmap[p] >= 0) begin
                eOe[p] = sDir[p] & sOe[tmap[p]];
                eOut[p] = pwmWave[tmap[p]];
            end
        end
        chkv(padOe, eOe, what);
        chkv(padOut & eOe, eOut & eOe, what);
        chkv(portInData, extLevel & ~sDir, what);
    endtask
    task automatic cfg(input logic [15:0] fu, fl, dir, input logic [7:0] oe);
        sFu = fu; sFl = fl; sDir = dir; sOe = oe;
        wr(OFS_PORT_FUNC_UPPER, fu);
        wr(OFS_PORT_FUNC_LOWER, fl);
        wr(OFS_PORT_DIRECTION_LOW, dir);
        wr(OFS_OUTPUT_MASTER_EN, {8'h00, oe});
        settle(3);
    endtask

    task automatic t_pins();
        logic [5:0] waves[4] = '{6'h15, 6'h2a, 6'h3f, 6'h00};
        @(posedge clk);
        portOutData <= 16'ha5a5;
        extLevel <= 16'h3cc3;
        cfg(16'h6666, 16'h6066, 16'hfb00, 8'hff);
        foreach (waves[i]) begin
            @(posedge clk);
            pwmWave <= waves[i];
            settle(3);
            chkpins("timer pins");
        end
        @(posedge clk);
        pwmWave <= 6'h3f;
        cfg(16'h6666, 16'h6066, 16'hfb00, 8'h00);
        chkpins("all disabled");
        cfg(16'h6666, 16'h6066, 16'hfb00, 8'h2a);
        chkpins("some disabled");
        cfg(16'h6666, 16'h6066, 16'h0b00, 8'hff);
        chkpins("timer inputs");
        cfg(16'h0666, 16'h6066, 16'hfb00, 8'hff);
        chkpins("port on upper");
        $display("test pins done");
    endtask

    initial begin
        rst_n = 1'b0; clkEn = 1'b1; regWr = 1'b0; regRd = 1'b0; compareAFlag = 1'b0;
        regAddr = '0; regWdata = '0; pwmWave = '0; portOutData = '0; extLevel = '0;
        sFu = '0; sFl = '0; sDir = '0; sOe = '0;
        n_fail = 0; tests_run = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_mode();
        t_start();
        t_irq();
        t_prio();
        t_pins();
        conclude();
    end

    // the whole run is under two hundred cycles; this bound is over twenty times that
    initial begin
        #(40 * 4000);
        n_fail++;
        $display("MISMATCH t=%0t watchdog expired", $time);
        conclude();
    end
endmodule
